// >>> design/ild_pkg.sv
package ild_pkg;

  // ---------------------------------------------------------------------------
  // Register map (channel addresses behind the indirect channel address)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ILD_ADDR_A_LOW  = 8'h00;
  localparam logic [7:0] ILD_ADDR_A_HIGH = 8'h01;
  localparam logic [7:0] ILD_ADDR_A_REL  = 8'h02;
  localparam logic [7:0] ILD_ADDR_A_CFG  = 8'h03;
  localparam logic [7:0] ILD_ADDR_B_LOW  = 8'h04;
  localparam logic [7:0] ILD_ADDR_B_HIGH = 8'h05;
  localparam logic [7:0] ILD_ADDR_B_REL  = 8'h06;
  localparam logic [7:0] ILD_ADDR_B_CFG  = 8'h07;
  localparam logic [7:0] ILD_PORT_STRIDE = 8'h04;

  // ---------------------------------------------------------------------------
  // External microport addresses and bits
  // ---------------------------------------------------------------------------
  localparam logic [2:0] ILD_EXT_SLEEP   = 3'h3;
  localparam logic [2:0] ILD_EXT_CHADDR  = 3'h6;
  localparam logic [2:0] ILD_EXT_DATA    = 3'h0;
  localparam int         ILD_SLEEP_ACCESS_BIT = 5;

  // ---------------------------------------------------------------------------
  // Widths, field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int ILD_LEVEL_W = 10;
  localparam int ILD_COUNT_W = 20;
  localparam int ILD_CFG_W   = 5;
  localparam int ILD_DELAY_W = 3;
  localparam int ILD_CFG_POL_BIT   = 4;
  localparam int ILD_CFG_ILEAV_BIT = 3;
  localparam logic [ILD_LEVEL_W-1:0] ILD_LEVEL_RST = 10'h000;
  localparam logic [ILD_COUNT_W-1:0] ILD_COUNT_RST = 20'h00000;
  localparam logic [ILD_CFG_W-1:0]   ILD_CFG_RST   = 5'h00;

  typedef enum logic [1:0]
  {
    ILD_IDLE  = 2'b00,
    ILD_HELD  = 2'b01,
    ILD_DWELL = 2'b10
  } ild_state_t;

endpackage

// >>> design/ild_port.sv
`timescale 1ns/1ns
module ild_port
#(
  parameter int LEVEL_W = ild_pkg::ILD_LEVEL_W,
  parameter int COUNT_W = ild_pkg::ILD_COUNT_W,
  parameter int DELAY_W = ild_pkg::ILD_DELAY_W
)
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // Sample and settings
  input  wire logic [LEVEL_W-1:0] sample_top,
  input  wire logic [LEVEL_W-1:0] low_level,
  input  wire logic [LEVEL_W-1:0] high_level,
  input  wire logic [COUNT_W-1:0] release_count,
  input  wire logic [DELAY_W-1:0] delay_sel,
  // Detection result, delayed
  output logic                    level_indicator
);
  import ild_pkg::*;

  localparam int DEPTH = (1 << DELAY_W) - 1;

  ild_state_t         state_ff;
  ild_state_t         nxt_state;
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  logic [DEPTH-1:0]   delay_ff;

  wire low_met   = (sample_top <= low_level);
  wire high_met  = (sample_top >= high_level);
  wire enabled   = (release_count != '0);
  wire raw_active = (state_ff != ILD_IDLE);

  // ---------------------------------------------------------------------------
  // Excursion and dwell tracking
  // ---------------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      ILD_IDLE:
      begin
        if (enabled && high_met)
          nxt_state = ILD_HELD;
      end
      ILD_HELD:
      begin
        // Between the thresholds the indicator stays set.
        if (low_met)
        begin
          nxt_state = ILD_DWELL;
          nxt_count = release_count;
        end
      end
      ILD_DWELL:
      begin
        if (!low_met)
        begin
          nxt_state = ILD_HELD;
          nxt_count = release_count;
        end
        else if (count_ff <= COUNT_W'(1))
          nxt_state = ILD_IDLE;
        else
          nxt_count = count_ff - COUNT_W'(1);
      end
      default: nxt_state = ILD_IDLE;
    endcase
    if (!enabled)
      nxt_state = ILD_IDLE;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= ILD_IDLE;
      count_ff <= '0;
      delay_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      delay_ff <= {delay_ff[DEPTH-2:0], raw_active};
    end
  end

  // Tap zero is one flop; each step of the setting adds a cycle of latency.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      level_indicator <= 1'b0;
    else
      level_indicator <= (delay_sel == '0) ? raw_active : delay_ff[delay_sel - 1'b1];
  end

endmodule

// >>> design/ild_top.sv
`timescale 1ns/1ns
module ild_top
#(
  parameter bit CHIP_SELECT_ONE_SET = 1'b0
)
(
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  // Microport
  input  wire logic                              chip_select_zero_n,
  input  wire logic                              chip_select_one_n,
  input  wire logic                              wr_n,
  input  wire logic                              rd_n,
  input  wire logic [2:0]                        ext_addr,
  input  wire logic [31:0]                       wr_data,
  output logic [31:0]                            rd_data,
  // Converter samples, top mantissa bits
  input  wire logic [ild_pkg::ILD_LEVEL_W-1:0]   port_a_sample,
  input  wire logic [ild_pkg::ILD_LEVEL_W-1:0]   port_b_sample,
  // Input enable pins
  input  wire logic                              port_a_input_enable,
  input  wire logic                              port_b_input_enable,
  // Level indicator pins
  output logic                                   port_a_indicator_first,
  output logic                                   port_a_indicator_second,
  output logic                                   port_b_indicator_first,
  output logic                                   port_b_indicator_second
);
  import ild_pkg::*;

  localparam int NP = 2;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Strobes and enables come from outside; two flops before any logic.
  logic [5:0] meta_ff;
  logic [5:0] sync_ff;
  logic       wr_seen_ff;
  logic       rd_seen_ff;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_ff <= 6'h3f;
      sync_ff <= 6'h3f;
    end
    else
    begin
      meta_ff <= {chip_select_zero_n, chip_select_one_n, wr_n, rd_n,
                  port_a_input_enable, port_b_input_enable};
      sync_ff <= meta_ff;
    end
  end

  wire cs_zero_s = ~sync_ff[5];
  wire cs_one_s  = ~sync_ff[4];
  wire wr_s      = ~sync_ff[3];
  wire rd_s      = ~sync_ff[2];
  wire [NP-1:0] ien_s = {sync_ff[0], sync_ff[1]};

  // The twin instance for the second port pair sets CHIP_SELECT_ONE_SET.
  wire selected  = CHIP_SELECT_ONE_SET ? cs_one_s : cs_zero_s;
  wire wr_pulse  = selected && wr_s && !wr_seen_ff;
  wire rd_pulse  = selected && rd_s && !rd_seen_ff;

  // Address and data are taken on the first clock of the synchronised strobe,
  // so the bus must hold them for three clocks after the strobe is asserted.
  // ---------------------------------------------------------------------------
  // Microport registers
  // ---------------------------------------------------------------------------
  logic       access_ff;
  logic [7:0] chaddr_ff;

  logic [ILD_LEVEL_W-1:0] low_ff   [NP];
  logic [ILD_LEVEL_W-1:0] high_ff  [NP];
  logic [ILD_COUNT_W-1:0] rel_ff   [NP];
  logic [ILD_CFG_W-1:0]   cfg_ff   [NP];

  wire wr_sleep  = wr_pulse && (ext_addr == ILD_EXT_SLEEP);
  wire wr_chaddr = wr_pulse && (ext_addr == ILD_EXT_CHADDR);
  wire wr_chan   = wr_pulse && (ext_addr == ILD_EXT_DATA) && access_ff;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_seen_ff <= 1'b0;
      rd_seen_ff <= 1'b0;
      access_ff  <= 1'b0;
      chaddr_ff  <= 8'h00;
    end
    else
    begin
      wr_seen_ff <= selected && wr_s;
      rd_seen_ff <= selected && rd_s;
      if (wr_sleep)
        access_ff <= wr_data[ILD_SLEEP_ACCESS_BIT];
      if (wr_chaddr)
        chaddr_ff <= wr_data[7:0];
    end
  end

  logic [NP-1:0] ind_raw;
  logic [NP-1:0] pin_first;
  logic [NP-1:0] pin_second;

  genvar p;
  generate
    for (p = 0; p < NP; p++)
    begin : g_port
      localparam logic [7:0] BASE = ILD_PORT_STRIDE * 8'(p);
      wire hit_low  = wr_chan && (chaddr_ff == BASE + ILD_ADDR_A_LOW);
      wire hit_high = wr_chan && (chaddr_ff == BASE + ILD_ADDR_A_HIGH);
      wire hit_rel  = wr_chan && (chaddr_ff == BASE + ILD_ADDR_A_REL);
      wire hit_cfg  = wr_chan && (chaddr_ff == BASE + ILD_ADDR_A_CFG);

      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          low_ff[p]  <= ILD_LEVEL_RST;
          high_ff[p] <= ILD_LEVEL_RST;
          rel_ff[p]  <= ILD_COUNT_RST;
          cfg_ff[p]  <= ILD_CFG_RST;
        end
        else
        begin
          if (hit_low)
            low_ff[p] <= wr_data[ILD_LEVEL_W-1:0];
          if (hit_high)
            high_ff[p] <= wr_data[ILD_LEVEL_W-1:0];
          if (hit_rel)
            rel_ff[p] <= wr_data[ILD_COUNT_W-1:0];
          if (hit_cfg)
            cfg_ff[p] <= wr_data[ILD_CFG_W-1:0];
        end
      end

      ild_port u_port
      (
        .core_clk        (core_clk),
        .reset           (reset),
        .sample_top      ((p == 0) ? port_a_sample : port_b_sample),
        .low_level       (low_ff[p]),
        .high_level      (high_ff[p]),
        .release_count   (rel_ff[p]),
        .delay_sel       (cfg_ff[p][ILD_DELAY_W-1:0]),
        .level_indicator (ind_raw[p])
      );

      wire pol   = cfg_ff[p][ILD_CFG_POL_BIT];
      wire ileav = cfg_ff[p][ILD_CFG_ILEAV_BIT];
      // Interleaved: idle pin shows inactive; single: second is complement.
      wire act_first  = ileav ? (ind_raw[p] && !ien_s[p]) : ind_raw[p];
      wire act_second = ileav ? (ind_raw[p] &&  ien_s[p]) : !ind_raw[p];
      assign pin_first[p]  = act_first ^ pol;
      assign pin_second[p] = act_second ^ pol;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  wire          rd_port = chaddr_ff[2];
  wire [1:0]    rd_sel  = chaddr_ff[1:0];
  wire          rd_hit  = access_ff && (chaddr_ff < 2 * ILD_PORT_STRIDE);
  logic [31:0]  rd_word;

  always_comb
  begin
    rd_word = 32'h00000000;
    if (ext_addr == ILD_EXT_CHADDR)
      rd_word = {24'h000000, chaddr_ff};
    else if (ext_addr == ILD_EXT_SLEEP)
      rd_word = 32'(access_ff) << ILD_SLEEP_ACCESS_BIT;
    else if (ext_addr == ILD_EXT_DATA && rd_hit)
    begin
      case (rd_sel)
        2'h0:    rd_word = 32'(low_ff[rd_port]);
        2'h1:    rd_word = 32'(high_ff[rd_port]);
        2'h2:    rd_word = 32'(rel_ff[rd_port]);
        2'h3:    rd_word = 32'(cfg_ff[rd_port]);
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_data                 <= 32'h00000000;
      port_a_indicator_first  <= 1'b0;
      port_a_indicator_second <= 1'b0;
      port_b_indicator_first  <= 1'b0;
      port_b_indicator_second <= 1'b0;
    end
    else
    begin
      if (rd_pulse)
        rd_data <= rd_word;
      port_a_indicator_first  <= pin_first[0];
      port_a_indicator_second <= pin_second[0];
      port_b_indicator_first  <= pin_first[1];
      port_b_indicator_second <= pin_second[1];
    end
  end

endmodule

// >>> tb/ild_gain_stage.sv
`timescale 1ns/1ns
module ild_gain_stage
(
  // Clock and requested input levels
  input  wire logic       core_clk,
  input  wire logic [9:0] level_a,
  input  wire logic [9:0] level_b,
  // Converter samples toward the detector
  output logic      [9:0] sample_a = 10'h000,
  output logic      [9:0] sample_b = 10'h000
);
  // One register stage stands for the converter ahead of the detector.
  always @(posedge core_clk)
  begin
    sample_a <= level_a;
    sample_b <= level_b;
  end
endmodule

// >>> tb/ild_properties.sv
`timescale 1ns/1ns
module ild_properties
  import ild_pkg::*;
(
  // Watched pins
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        chip_select_zero_n,
  input wire logic        wr_n,
  input wire logic        rd_n,
  input wire logic [2:0]  ext_addr,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] rd_data,
  input wire logic [9:0]  port_a_sample,
  input wire logic [9:0]  port_b_sample,
  input wire logic        port_a_input_enable,
  input wire logic        port_b_input_enable,
  input wire logic        port_a_indicator_first,
  input wire logic        port_a_indicator_second,
  input wire logic        port_b_indicator_first,
  input wire logic        port_b_indicator_second
);
  // ---------------------------------------------------------------
  // Settings shadow
  // ---------------------------------------------------------------
  // All checks but chk_reset_idle and chk_read_hold wait for a quiet bus, so a setting still settling never trips them.
  logic        acc_ff;
  logic [7:0]  ch_ff;
  logic [31:0] sh_ff [8];
  logic [4:0]  qt_ff;
  logic        wr_hit;
  logic        quiet;
  logic        on_a;
  logic        on_b;
  logic [4:0]  cfg_a;
  logic [4:0]  cfg_b;
  assign wr_hit = !wr_n && !chip_select_zero_n;
  assign quiet  = qt_ff == 5'h14;
  assign cfg_a  = sh_ff[3][4:0];
  assign cfg_b  = sh_ff[7][4:0];
  assign on_a   = quiet && sh_ff[2][19:0] != 20'h00000;
  assign on_b   = quiet && sh_ff[6][19:0] != 20'h00000;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ch_ff <= 8'h00;
      acc_ff <= 1'b0;
      sh_ff <= '{default: 32'h0};
      qt_ff <= 5'h00;
    end
    else
    begin
      qt_ff <= wr_hit ? 5'h00 : qt_ff + {4'h0, !quiet};
      if (wr_hit && ext_addr == ILD_EXT_CHADDR)
        ch_ff <= wr_data[7:0];
      if (wr_hit && ext_addr == ILD_EXT_SLEEP)
        acc_ff <= wr_data[ILD_SLEEP_ACCESS_BIT];
      if (wr_hit && ext_addr == ILD_EXT_DATA && ch_ff < 8'h08 && acc_ff)
        sh_ff[ch_ff[2:0]] <= wr_data;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_hit_a;
    on_a && cfg_a == 5'h00 && port_a_sample >= sh_ff[1][9:0];
  endsequence
  sequence s_hit_b;
    on_b && cfg_b == 5'h00 && port_b_sample >= sh_ff[5][9:0];
  endsequence
  sequence s_sel_a;
    (quiet && cfg_a[3] && port_a_input_enable) [*6];
  endsequence
  sequence s_sel_b;
    (quiet && cfg_b[3] && !port_b_input_enable) [*6];
  endsequence
  chk_reset_idle: assert property ($fell(reset) |-> {port_a_indicator_first,
    port_a_indicator_second, port_b_indicator_first, port_b_indicator_second} == 4'h0)
    else $error("indicator active at reset release");
  chk_upper_hit_a: assert property (s_hit_a |-> ##3 port_a_indicator_first)
    else $error("port a hit not indicated");
  chk_upper_hit_b: assert property (s_hit_b |-> ##3 port_b_indicator_first)
    else $error("port b hit not indicated");
  chk_single_pair_a: assert property (quiet && !cfg_a[3] |->
    port_a_indicator_second != port_a_indicator_first) else $error("port a pair equal");
  chk_single_pair_b: assert property (quiet && !cfg_b[3] |->
    port_b_indicator_second != port_b_indicator_first) else $error("port b pair equal");
  chk_steer_a: assert property (s_sel_a |-> port_a_indicator_first == cfg_a[4])
    else $error("port a first pin not idle");
  chk_steer_b: assert property (s_sel_b |-> port_b_indicator_second == cfg_b[4])
    else $error("port b second pin not idle");
  chk_dwell_off: assert property (quiet && !on_a |-> port_a_indicator_first == cfg_a[4])
    else $error("port a active with dwell zero");
  chk_read_hold: assert property ($changed(rd_data) |-> !$past(rd_n, 3))
    else $error("read data moved without a read");
endmodule
bind ild_top ild_properties u_chk (.core_clk, .reset, .chip_select_zero_n, .wr_n, .rd_n,
  .ext_addr, .wr_data, .rd_data, .port_a_sample, .port_b_sample, .port_a_input_enable,
  .port_b_input_enable, .port_a_indicator_first, .port_a_indicator_second,
  .port_b_indicator_first, .port_b_indicator_second);

// >>> tb/ild_top_tb.sv
`timescale 1ns/1ns
module ild_top_tb;
  import ild_pkg::*;
  // ---------------------------------------------------------------
  // Pins, partner and design
  // ---------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        chip_select_zero_n = 1'b1;
  logic        chip_select_one_n = 1'b1;
  logic        wr_n = 1'b1;
  logic        rd_n = 1'b1;
  logic [2:0]  ext_addr = 3'h0;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic [9:0]  level_a = 10'h000;
  logic [9:0]  level_b = 10'h000;
  logic [9:0]  port_a_sample;
  logic [9:0]  port_b_sample;
  logic        port_a_input_enable = 1'b0;
  logic        port_b_input_enable = 1'b0;
  logic        port_a_indicator_first;
  logic        port_a_indicator_second;
  logic        port_b_indicator_first;
  logic        port_b_indicator_second;
  int          n_errors = 0;
  int          check_count = 0;
  ild_gain_stage u_src (.core_clk, .level_a, .level_b, .sample_a(port_a_sample),
    .sample_b(port_b_sample));
  ild_top dut (.core_clk, .reset, .chip_select_zero_n, .chip_select_one_n, .wr_n, .rd_n,
    .ext_addr, .wr_data, .rd_data, .port_a_sample, .port_b_sample, .port_a_input_enable,
    .port_b_input_enable, .port_a_indicator_first, .port_a_indicator_second,
    .port_b_indicator_first, .port_b_indicator_second);
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  function automatic logic [1:0] pins(bit p);
    return p ? {port_b_indicator_first, port_b_indicator_second}
             : {port_a_indicator_first, port_a_indicator_second};
  endfunction
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Strobes are held six clocks, past the three-clock settling of the pin sync.
  task automatic bus(bit w, bit cs1, logic [2:0] a, logic [31:0] d);
    @(posedge core_clk);
    ext_addr <= a;
    wr_data <= d;
    chip_select_zero_n <= cs1;
    chip_select_one_n <= !cs1;
    wr_n <= !w;
    rd_n <= w;
    repeat (6) @(posedge core_clk);
    {wr_n, rd_n, chip_select_zero_n, chip_select_one_n} <= 4'hf;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wreg(bit cs1, logic [7:0] ch, logic [31:0] d);
    bus(1'b1, cs1, ILD_EXT_CHADDR, {24'h0, ch});
    bus(1'b1, cs1, ILD_EXT_DATA, d);
  endtask
  task automatic rreg(logic [7:0] ch, logic [31:0] exp);
    bus(1'b1, 1'b0, ILD_EXT_CHADDR, {24'h0, ch});
    bus(1'b0, 1'b0, ILD_EXT_DATA, 32'h0);
    check("register", exp, rd_data);
  endtask
  task automatic setup(bit p, logic [31:0] lo, logic [31:0] hi, logic [31:0] rel,
    logic [31:0] cfg);
    wreg(1'b0, {5'h0, p, 2'h0}, lo);
    wreg(1'b0, {5'h0, p, 2'h1}, hi);
    wreg(1'b0, {5'h0, p, 2'h2}, rel);
    wreg(1'b0, {5'h0, p, 2'h3}, cfg);
  endtask
  task automatic lvl(bit p, logic [9:0] v, int wait_n);
    @(posedge core_clk);
    if (p)
      level_b <= v;
    else
      level_a <= v;
    repeat (wait_n) @(posedge core_clk);
    #1;
  endtask
  task automatic lat(bit p, logic [9:0] v, logic want, output int n);
    lvl(p, v, 0);
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end while ((p ? port_b_indicator_first : port_a_indicator_first) !== want && n < 60);
    if (n >= 60)
    begin
      n_errors++;
      summarize();
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    wreg(1'b0, ILD_ADDR_A_HIGH, 32'h3ff);
    bus(1'b1, 1'b0, ILD_EXT_SLEEP, 32'h20);
    for (int i = 0; i < 9; i++)
    begin
      rreg(i[7:0], 32'h0);
      wreg(1'b0, i[7:0], 32'hffffffff);
      rreg(i[7:0], i == 8 ? 32'h0 : i % 4 == 2 ? 32'hfffff : i % 4 == 3 ? 32'h1f : 32'h3ff);
    end
    wreg(1'b1, ILD_ADDR_A_LOW, 32'h5);
    rreg(ILD_ADDR_A_LOW, 32'h3ff);
    bus(1'b0, 1'b0, ILD_EXT_SLEEP, 32'h0);
    check("sleep", 32'h20, rd_data);
  endtask
  task automatic t_detect(bit p);
    int n;
    lvl(p, 10'd499, 25);
    check("below upper", 2'b01, pins(p));
    lat(p, 10'd500, 1'b1, n);
    check("hit latency", 4, n);
    check("other port", 2'b01, pins(!p));
    lvl(p, 10'd300, 20);
    check("between", 2'b10, pins(p));
    lvl(p, 10'd100, 3);
    lvl(p, 10'd101, 8);
    check("reload", 2'b10, pins(p));
    lat(p, 10'd100, 1'b0, n);
    check("release latency", 5 + 4, n);
  endtask
  task automatic t_modes();
    int n;
    setup(1'b0, 100, 500, 5, 5'h10);
    lvl(1'b0, 10'd100, 25);
    check("low polarity idle", 2'b10, pins(1'b0));
    lat(1'b0, 10'd500, 1'b0, n);
    check("low polarity hit", 2'b01, pins(1'b0));
    setup(1'b0, 100, 500, 5, 5'h08);
    setup(1'b1, 100, 500, 5, 5'h08);
    @(posedge core_clk);
    port_a_input_enable <= 1'b1;
    lvl(1'b0, 10'd500, 25);
    check("steer second", 2'b01, pins(1'b0));
    @(posedge core_clk);
    port_a_input_enable <= 1'b0;
    lvl(1'b0, 10'd500, 10);
    check("steer first", 2'b10, pins(1'b0));
    @(posedge core_clk);
    port_b_input_enable <= 1'b1;
    lvl(1'b1, 10'd500, 25);
    check("steer b second", 2'b01, pins(1'b1));
    @(posedge core_clk);
    port_b_input_enable <= 1'b0;
    lvl(1'b1, 10'd500, 10);
    check("steer b first", 2'b10, pins(1'b1));
    setup(1'b0, 100, 500, 5, 5'h07);
    lvl(1'b0, 10'd100, 40);
    lat(1'b0, 10'd500, 1'b1, n);
    check("delayed hit", 4 + 7, n);
    setup(1'b0, 100, 500, 0, 5'h00);
    lvl(1'b0, 10'd600, 25);
    check("dwell zero", 2'b01, pins(1'b0));
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    setup(1'b0, 100, 500, 5, 5'h00);
    setup(1'b1, 100, 500, 5, 5'h00);
    t_detect(1'b0);
    t_detect(1'b1);
    t_modes();
    summarize();
  end
endmodule
